// *** rtl/cvps_slave.sv ***
// Operation
// [R01] Master opens every transaction with data falling while clock is high.
// [R02] First byte holds seven address bits and a direction bit.
// [R03] Matching address is acknowledged by driving data low on ninth clock.
// [R04] Each written data byte is acknowledged low on its ninth clock.
// [R05] Bytes continue back to back until stop or repeated start.
// [R06] Written byte is latched on acknowledge clock rise and applied at once.
// [R07] Four-bit voltage code drives the reference converter.
// [R08] Read shifts the current program byte out on the data line.
// [R09] Master ends a read with not-acknowledge and then stop.
// [R10] Stop is data rising while clock is high.
// [R11] Bits 3..0 are voltage code, bits 5..4 slew code.
// [R12] Each field is sent most significant bit first.
// [R13] Slew code selects 5, 10, 24 or 47 microamp soft-start current.
// [R14] Slew code defaults to 01 after power-up.
// [R15] Overvoltage above 114% for over 1.5 us trips; clears at 106%.
// [R16] Undervoltage below 86% flags; clears after recovery to 94%.
// [R17] Power good low until all outputs in tolerance, unlatched.
// [R18] Select high disables bus and uses pins as voltage code bits 0,1.
// [R19] Voltage code maps to 850 mV plus 50 mV per step.
// [R20] Bus mode starts at voltage code 1001.
// [R21] Programmed codes are kept through enable-low periods.
// [R22] Address is a parameter; mismatching transactions are ignored, no ack.
// [R23] Bits 7 and 6 of a written byte are ignored.
`default_nettype none
module cvps_slave
	import cvps_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = cvps_pkg::SLAVE_ADDR_DEFAULT,
	parameter int         OV_CYC     = cvps_pkg::OV_DELAY_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   pinFunctionSelect,
	input  wire logic                   sclIn,
	input  wire logic                   sdaIn,
	output logic                        sdaOut,
	output logic                        sdaOe,
	input  wire logic [3:2]             voltageCodePins,
	input  wire logic                   regEnable,
	input  wire logic [7:0]             voutPct,
	input  wire logic                   ldoSramOk,
	input  wire logic                   ldoPllOk,
	output cvps_pkg::cvps_setting_type  activeSetting,
	output logic [10:0]                 vrefMv,
	output logic [5:0]                  softStartUa,
	output logic                        ovFault,
	output logic                        uvFault,
	output logic                        phaseTristate,
	output logic                        powerGoodOut,
	output logic                        powerGoodOe
);
	import cvps_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [SYNC_STAGES-1:0] sclSync_r, sdaSync_r, selSync_r, enSync_r;
	logic [1:0] vpinSync0_r, vpinSync1_r;
	logic sclD_r, sdaD_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclSync_r   <= '1;
			sdaSync_r   <= '1;
			selSync_r   <= '0;
			enSync_r    <= '0;
			vpinSync0_r <= '0;
			vpinSync1_r <= '0;
			sclD_r      <= 1'b1;
			sdaD_r      <= 1'b1;
		end else begin
			sclSync_r   <= {sclSync_r[0], sclIn};
			sdaSync_r   <= {sdaSync_r[0], sdaIn};
			selSync_r   <= {selSync_r[0], pinFunctionSelect};
			enSync_r    <= {enSync_r[0], regEnable};
			vpinSync0_r <= voltageCodePins;
			vpinSync1_r <= vpinSync0_r;
			sclD_r      <= sclSync_r[1];
			sdaD_r      <= sdaSync_r[1];
		end
	end
	logic scl, sda, busOn, sclRise, sclFall, startSeen, stopSeen;
	assign scl       = sclSync_r[1];
	assign sda       = sdaSync_r[1];
	assign busOn     = !selSync_r[1];  // [R18]
	assign sclRise   = busOn && scl && !sclD_r;
	assign sclFall   = busOn && !scl && sclD_r;
	assign startSeen = busOn && scl && sclD_r && sdaD_r && !sda;  // [R01]
	assign stopSeen  = busOn && scl && sclD_r && !sdaD_r && sda;  // [R10]

	// ****************************************
	// Bus protocol engine
	// ****************************************
	cvps_state_type state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [3:0] bitCnt_r, bitCnt_nxt;
	logic       drive_r, drive_nxt;
	cvps_setting_type prog_r, prog_nxt;
	always_comb begin
		state_nxt  = state_r;
		shift_nxt  = shift_r;
		bitCnt_nxt = bitCnt_r;
		drive_nxt  = drive_r;
		prog_nxt   = prog_r;
		if (!busOn || stopSeen) begin
			state_nxt = ST_IDLE;
			drive_nxt = 1'b0;
		end else if (startSeen) begin  // [R05]
			state_nxt  = ST_ADDR;
			bitCnt_nxt = 4'h0;
			drive_nxt  = 1'b0;
		end else begin
			case (state_r)
				ST_ADDR, ST_WDATA: begin
					if (sclRise) begin
						shift_nxt  = {shift_r[6:0], sda};  // [R12]
						bitCnt_nxt = bitCnt_r + 4'h1;
					end
					if (sclFall && bitCnt_r == 4'h8) begin
						if (state_r == ST_WDATA) begin
							state_nxt = ST_WACK;
							drive_nxt = 1'b1;  // [R04]
						end else if (shift_r[7:1] == SLAVE_ADDR) begin  // [R02]
							state_nxt = ST_AACK;
							drive_nxt = 1'b1;  // [R03]
						end else begin
							state_nxt = ST_IGNORE;  // [R22]
						end
					end
				end
				ST_AACK: begin
					if (sclFall) begin
						bitCnt_nxt = 4'h0;
						if (shift_r[0]) begin
							state_nxt = ST_RDATA;
							shift_nxt = {2'b00, prog_r};  // [R08]
							drive_nxt = !shift_nxt[7];
						end else begin
							state_nxt = ST_WDATA;
							drive_nxt = 1'b0;
						end
					end
				end
				ST_WACK: begin
					if (sclRise) begin
						prog_nxt.vcode = shift_r[VCODE_LSB +: VCODE_W];  // [R06] [R11] [R23]
						prog_nxt.slew  = shift_r[SLEW_LSB +: SLEW_W];
					end
					if (sclFall) begin
						state_nxt  = ST_WDATA;  // [R05]
						bitCnt_nxt = 4'h0;
						drive_nxt  = 1'b0;
					end
				end
				ST_RDATA: begin
					if (sclFall) begin
						bitCnt_nxt = bitCnt_r + 4'h1;
						shift_nxt  = {shift_r[6:0], 1'b0};  // [R12]
						if (bitCnt_r == 4'h7) begin
							state_nxt = ST_RACK;
							drive_nxt = 1'b0;
						end else begin
							drive_nxt = !shift_r[6];
						end
					end
				end
				ST_RACK: begin
					if (sclRise && sda) begin
						state_nxt = ST_IGNORE;  // [R09]
					end else if (sclFall) begin
						state_nxt = ST_RDATA;
						bitCnt_nxt = 4'h0;
						shift_nxt = {2'b00, prog_r};
						drive_nxt = !shift_nxt[7];
					end
				end
				ST_IDLE, ST_IGNORE: begin
					drive_nxt = 1'b0;
				end
				default: begin
					state_nxt = ST_IDLE;
					drive_nxt = 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r  <= ST_IDLE;
			shift_r  <= 8'h00;
			bitCnt_r <= 4'h0;
			drive_r  <= 1'b0;
			prog_r   <= '{slew: SLEW_RESET, vcode: VCODE_RESET};  // [R14] [R20]
		end else begin
			state_r  <= state_nxt;
			shift_r  <= shift_nxt;
			bitCnt_r <= bitCnt_nxt;
			drive_r  <= drive_nxt;
			prog_r   <= prog_nxt;  // [R21]
		end
	end
	assign sdaOut = 1'b0;
	assign sdaOe  = !drive_r;

	// ****************************************
	// Reference and slew decode
	// ****************************************
	function automatic logic [5:0] slewCurrent(input logic [1:0] code);
		case (code)
			2'h0:    slewCurrent = SS_CUR_00;
			2'h1:    slewCurrent = SS_CUR_01;
			2'h2:    slewCurrent = SS_CUR_10;
			default: slewCurrent = SS_CUR_11;
		endcase
	endfunction : slewCurrent
	cvps_setting_type setting_nxt, setting_r;
	logic [10:0] vref_nxt, vref_r;
	logic [5:0]  ss_nxt, ss_r;
	always_comb begin
		setting_nxt = prog_r;
		if (!busOn) begin
			setting_nxt.vcode = {vpinSync1_r, sclSync_r[1], sdaSync_r[1]};  // [R18]
			setting_nxt.slew  = SLEW_RESET;
		end
		vref_nxt = VREF_BASE_MV + 11'(setting_nxt.vcode) * VREF_STEP_MV;  // [R07] [R19]
		ss_nxt   = slewCurrent(setting_nxt.slew);  // [R13]
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			setting_r <= '{slew: SLEW_RESET, vcode: VCODE_RESET};
			vref_r    <= VREF_BASE_MV + 11'(VCODE_RESET) * VREF_STEP_MV;  // [R20]
			ss_r      <= SS_CUR_01;
		end else begin
			setting_r <= setting_nxt;
			vref_r    <= vref_nxt;
			ss_r      <= ss_nxt;
		end
	end
	assign activeSetting = setting_r;
	assign vrefMv        = vref_r;
	assign softStartUa   = ss_r;

	// ****************************************
	// Output faults and power good
	// ****************************************
	logic [15:0] ovCnt_r, ovCnt_nxt;
	logic ov_r, ov_nxt, uv_r, uv_nxt, pg_r, pg_nxt;
	always_comb begin
		ovCnt_nxt = (voutPct > OV_TRIP_PCT) ? ovCnt_r + 16'h1 : 16'h0;
		if (ovCnt_r == 16'(OV_CYC) && voutPct > OV_TRIP_PCT)
			ovCnt_nxt = ovCnt_r;
		ov_nxt = ov_r;
		if (ovCnt_r == 16'(OV_CYC))
			ov_nxt = 1'b1;  // [R15]
		else if (voutPct <= OV_CLEAR_PCT)
			ov_nxt = 1'b0;  // [R15]
		uv_nxt = uv_r;
		if (voutPct < UV_TRIP_PCT)
			uv_nxt = 1'b1;  // [R16]
		else if (voutPct >= UV_CLEAR_PCT)
			uv_nxt = 1'b0;  // [R16]
		pg_nxt = enSync_r[1] && !ov_r && !uv_r && ldoSramOk && ldoPllOk;  // [R17]
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ovCnt_r <= 16'h0;
			ov_r    <= 1'b0;
			uv_r    <= 1'b0;
			pg_r    <= 1'b0;
		end else begin
			ovCnt_r <= ovCnt_nxt;
			ov_r    <= ov_nxt;
			uv_r    <= uv_nxt;
			pg_r    <= pg_nxt;
		end
	end
	assign ovFault       = ov_r;
	assign uvFault       = uv_r;
	assign phaseTristate = ov_r;
	assign powerGoodOut  = 1'b0;
	assign powerGoodOe   = pg_r;

	// ****************************************
	// Checks
	// ****************************************
	AST_ADDR_ACK: assert property (@(posedge clk) disable iff (!nrst) // [R03]
		(state_r == ST_ADDR && sclFall && bitCnt_r == 4'h8 && shift_r[7:1] == SLAVE_ADDR)
		|=> !sdaOe && state_r == ST_AACK) else $error("address ack missing");
	AST_NO_ACK: assert property (@(posedge clk) disable iff (!nrst) // [R22]
		(state_r == ST_IGNORE) |-> sdaOe) else $error("driving while ignored");
	AST_WACK: assert property (@(posedge clk) disable iff (!nrst) // [R04]
		(state_r == ST_WDATA && sclFall && bitCnt_r == 4'h8 && busOn && !stopSeen && !startSeen)
		|=> !sdaOe) else $error("write ack missing");
	AST_LATCH: assert property (@(posedge clk) disable iff (!nrst) // [R06]
		(state_r == ST_WACK && sclRise && !stopSeen && !startSeen && busOn)
		|=> prog_r.vcode == $past(shift_r[3:0]) && prog_r.slew == $past(shift_r[5:4]))
		else $error("program byte not latched");
	AST_VREF: assert property (@(posedge clk) disable iff (!nrst) // [R19]
		vrefMv == 11'(VREF_BASE_MV + 11'(activeSetting.vcode) * VREF_STEP_MV))
		else $error("reference mapping wrong");
	AST_OV_TRIP: assert property (@(posedge clk) disable iff (!nrst) // [R15]
		(ovCnt_r == 16'(OV_CYC)) |=> ovFault && phaseTristate) else $error("ov not tripped");
	AST_UV: assert property (@(posedge clk) disable iff (!nrst) // [R16]
		(voutPct < UV_TRIP_PCT) |=> uvFault) else $error("uv not flagged");
	AST_PG: assert property (@(posedge clk) disable iff (!nrst) // [R17]
		(ov_r || uv_r) |=> !powerGoodOe) else $error("power good during fault");
	AST_SEL: assert property (@(posedge clk) disable iff (!nrst) // [R18]
		!busOn |=> state_r == ST_IDLE && sdaOe) else $error("bus active in pin mode");
endmodule : cvps_slave
`default_nettype wire

// *** rtl/cvps_pkg.sv ***
`default_nettype none
package cvps_pkg;
	// ****************************************
	// Program byte layout
	// ****************************************
	localparam int VCODE_LSB = 0;
	localparam int VCODE_W = 4;
	localparam int SLEW_LSB = 4;
	localparam int SLEW_W = 2;
	localparam logic [3:0] VCODE_RESET = 4'h9;
	localparam logic [1:0] SLEW_RESET = 2'h1;
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2a;
	// ****************************************
	// Reference voltage in millivolts
	// ****************************************
	localparam logic [10:0] VREF_BASE_MV = 11'h352;
	localparam logic [10:0] VREF_STEP_MV = 11'h032;
	// ****************************************
	// Soft-start source current in microamps
	// ****************************************
	localparam logic [5:0] SS_CUR_00 = 6'h05;
	localparam logic [5:0] SS_CUR_01 = 6'h0a;
	localparam logic [5:0] SS_CUR_10 = 6'h18;
	localparam logic [5:0] SS_CUR_11 = 6'h2f;
	// ****************************************
	// Fault thresholds, percent of reference, and timing
	// ****************************************
	localparam logic [7:0] OV_TRIP_PCT = 8'h72;
	localparam logic [7:0] OV_CLEAR_PCT = 8'h6a;
	localparam logic [7:0] UV_TRIP_PCT = 8'h56;
	localparam logic [7:0] UV_CLEAR_PCT = 8'h5e;
	localparam int CLK_MHZ = 200;
	localparam int OV_DELAY_NS = 1500;
	localparam int OV_DELAY_CYC = (OV_DELAY_NS * CLK_MHZ) / 1000;
	localparam int SYNC_STAGES = 2;
	typedef struct packed {
		logic [1:0] slew;
		logic [3:0] vcode;
	} cvps_setting_type;
	typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_IGNORE}
		cvps_state_type;
endpackage : cvps_pkg
`default_nettype wire

// *** test/cvps_master.sv ***
`default_nettype none
module cvps_master (
	input  wire logic clk,
	input  wire logic sdaLine,
	output logic      scl,
	output logic      sdaLow
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Bus master, quarter bit of four clocks
	// ****************************************
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic quarter;
		repeat (4) @(posedge clk);
	endtask : quarter
	task automatic start;
		sdaLow <= 1'b0;
		quarter();
		scl <= 1'b1;
		quarter();
		sdaLow <= 1'b1;
		quarter();
		scl <= 1'b0;
		quarter();
	endtask : start
	task automatic stop;
		sdaLow <= 1'b1;
		quarter();
		scl <= 1'b1;
		quarter();
		sdaLow <= 1'b0;
		quarter();
	endtask : stop
	task automatic bitx(input logic b, output logic r);
		sdaLow <= ~b;
		quarter();
		scl <= 1'b1;
		quarter();
		r = sdaLine;
		quarter();
		scl <= 1'b0;
		quarter();
	endtask : bitx
	task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
			q[i] = r;
		end
		bitx(ackIn, ack);
	endtask : xfer
endmodule : cvps_master
`default_nettype wire

// *** test/testbench.sv ***
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cvps_pkg::*;
	localparam int         OV_N = 10;
	localparam logic [6:0] ADDR = 7'h35;
	localparam logic [7:0] PCT [8] = '{8'h73, 8'h64, 8'h73, 8'h6b, 8'h6a, 8'h55, 8'h5d, 8'h5e};
	localparam int         WT [8] = '{OV_N - 3, 4, OV_N + 5, 4, 4, 4, 4, 4};
	localparam logic [1:0] FL [8] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0};
	localparam logic [5:0] SS [4] = '{6'h05, 6'h0a, 6'h18, 6'h2f};
	logic             clk, nrst, pinSel, regEn, ldoS, ldoP, scl, sdaLow, sdaOe, sdaOut;
	logic             ovFault, uvFault, triState, pgOe, sdaLine, pgOut;
	logic [1:0]       hiPins;
	logic [7:0]       voutPct, b0, b1, q;
	logic [10:0]      vrefMv;
	logic [5:0]       ssUa, cur;
	logic [31:0]      r;
	int               errors, checks, seed;
	cvps_setting_type setting;
	logic [5:0]       expQ [$];
	assign sdaLine = ~sdaLow & (sdaOe | sdaOut);
	cvps_slave #(.SLAVE_ADDR(ADDR), .OV_CYC(OV_N)) uut (
		.clk(clk), .nrst(nrst), .pinFunctionSelect(pinSel), .sclIn(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .voltageCodePins(hiPins), .regEnable(regEn),
		.voutPct(voutPct), .ldoSramOk(ldoS), .ldoPllOk(ldoP), .activeSetting(setting),
		.vrefMv(vrefMv), .softStartUa(ssUa), .ovFault(ovFault), .uvFault(uvFault),
		.phaseTristate(triState), .powerGoodOut(pgOut), .powerGoodOe(pgOe));
	cvps_master host (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ****************************************
	// Checking
	// ****************************************
	task automatic check(input logic [10:0] e, input logic [10:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH at %0t: expected %h got %h", $time, e, g);
		end
	endtask : check
	always @(setting) begin
		if (nrst === 1'b1) begin
			check(expQ.size() ? expQ.pop_front() : ~setting, setting);
		end
	end
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	task automatic settle;
		int n;
		n = 0;
		while (expQ.size() != 0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n == 400) begin
			errors++;
			wrap_up();
		end
	endtask : settle
	// ****************************************
	// Bus transactions
	// ****************************************
	task automatic wr(input logic [6:0] a, input logic [7:0] d0, d1, input logic ok);
		logic ack;
		host.start();
		host.xfer({a, 1'b0}, 1'b1, q, ack);
		check(!ok, ack);
		host.xfer(d0, 1'b1, q, ack);
		check(!ok, ack);
		host.xfer(d1, 1'b1, q, ack);
		check(!ok, ack);
		host.stop();
	endtask : wr
	task automatic rd;
		logic ack;
		host.start();
		host.xfer({ADDR, 1'b1}, 1'b1, q, ack);
		check(1'b0, ack);
		host.xfer(8'hff, 1'b1, q, ack);
		host.stop();
	endtask : rd
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 32'h2f90;
		errors = 0;
		checks = 0;
		{nrst, pinSel, hiPins} = 4'h0;
		{regEn, ldoS, ldoP} = 3'h7;
		voutPct = 8'h64;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		cur = 6'h19;
		check(cur, setting);
		check(11'h514, vrefMv);
		check(6'h0a, ssUa);
		check(1'b1, pgOe);
		check(1'b0, pgOut);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			b0 = {r[7:6], i[1:0], cur[3:0] ^ (r[3:0] | 4'h1)};
			b1 = b0 ^ {r[9:8], 6'h3f};
			expQ.push_back(b0[5:0]);
			expQ.push_back(b1[5:0]);
			wr(ADDR, b0, b1, 1'b1);
			settle();
			cur = b1[5:0];
			check(11'h352 + 11'h032 * b1[3:0], vrefMv);
			check(SS[b1[5:4]], ssUa);
			rd();
			check({2'h0, cur}, q);
		end
		$display("test write and read done");
		wr(ADDR ^ 7'h01, 8'h00, 8'hff, 1'b0);
		repeat (8) @(posedge clk);
		check(cur, setting);
		$display("test foreign address done");
		hiPins <= ~cur[3:2];
		pinSel <= 1'b1;
		expQ.push_back({2'h1, ~cur[3:2], 2'h3});
		settle();
		repeat (4) @(posedge clk);
		check(11'h352 + 11'h032 * {~cur[3:2], 2'h3}, vrefMv);
		check(6'h0a, ssUa);
		pinSel <= 1'b0;
		expQ.push_back(cur);
		settle();
		$display("test pin mode done");
		for (int k = 0; k < 3; k++) begin
			{regEn, ldoS, ldoP} <= ~(3'h4 >> k);
			repeat (4) @(posedge clk);
			check(1'b0, pgOe);
			{regEn, ldoS, ldoP} <= 3'h7;
			repeat (4) @(posedge clk);
			check(1'b1, pgOe);
		end
		check(cur, setting);
		$display("test power good done");
		for (int k = 0; k < 8; k++) begin
			voutPct <= PCT[k];
			repeat (WT[k]) @(posedge clk);
			check(FL[k], {ovFault, uvFault});
			check(FL[k][1], triState);
			check(~|FL[k], pgOe);
		end
		$display("test faults done");
		check(11'h000, 11'(expQ.size()));
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
